// ===== mbfh_checker_properties.sv
// Port timing checker of the function handler
module mbfh_checker (
	input wire logic        i_core_clk,
	input wire logic        i_rst,
	input wire logic        i_rx_frame_end,
	input wire logic        i_tx_ready,
	input wire logic [7:0]  o_tx_data,
	input wire logic        o_tx_valid,
	input wire logic        o_commit_valid,
	input wire logic [15:0] o_commit_addr,
	input wire logic        o_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        seen_reg;
	logic [15:0] last_reg;
	////////////////////////////////////////
	// Previous commit of the same frame
	always @(posedge i_core_clk)
	begin
		if (i_rst || i_rx_frame_end)
			seen_reg <= 1'h0;
		else if (o_commit_valid)
			seen_reg <= 1'h1;
		if (o_commit_valid)
			last_reg <= o_commit_addr;
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	////////////////////////////////////////
	tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
		else $error("tx byte lost");
	tx_gap_a: assert property (o_tx_valid && i_tx_ready |=> !o_tx_valid [*2])
		else $error("tx bytes too close");
	commit_asc_a: assert property (o_commit_valid && seen_reg |-> o_commit_addr > last_reg)
		else $error("commit not ascending");
	commit_gap_a: assert property (o_commit_valid |=> !o_commit_valid [*2])
		else $error("commits too close");
	commit_first_a: assert property (o_tx_valid |-> !o_commit_valid)
		else $error("commit during reply");
	busy_cause_a: assert property ($rose(o_busy) |-> $past(i_rx_frame_end))
		else $error("busy without frame end");
	reply_delay_a: assert property ($rose(o_busy) |-> !o_tx_valid ##1 !o_tx_valid)
		else $error("reply too early");
	idle_quiet_a: assert property (!o_busy |-> !o_tx_valid && !o_commit_valid)
		else $error("output while idle");
	cover property (o_commit_valid && seen_reg);
	cover property (o_tx_valid && !i_tx_ready);
	cover property ($rose(o_busy));
endmodule // mbfh_checker

bind mbfh_top mbfh_checker mbfh_checker_inst (
	.i_core_clk     (i_core_clk),
	.i_rst          (i_rst),
	.i_rx_frame_end (i_rx_frame_end),
	.i_tx_ready     (i_tx_ready),
	.o_tx_data      (o_tx_data),
	.o_tx_valid     (o_tx_valid),
	.o_commit_valid (o_commit_valid),
	.o_commit_addr  (o_commit_addr),
	.o_busy         (o_busy)
);

// ===== mbfh_defines.vh
// Constants of the function handler: function codes, frame offsets, CRC and reply kinds
`ifndef MBFH_DEFINES_VH
`define MBFH_DEFINES_VH

`define MBFH_FN_READ      8'h03
`define MBFH_FN_WRITE1    8'h06
`define MBFH_FN_DIAG      8'h08
`define MBFH_FN_WRITEN    8'h10
`define MBFH_SUB_ECHO     16'h0000
`define MBFH_EXC_FLAG     8'h80
`define MBFH_EXC_ADDR     8'h02

`define MBFH_CRC_INIT     16'hffff
`define MBFH_CRC_POLY     16'ha001

// Byte offsets within a query frame
`define MBFH_OFS_SLAVE    8'h00
`define MBFH_OFS_FN       8'h01
`define MBFH_OFS_DATA1    8'h04
`define MBFH_OFS_DATAN    8'h07
`define MBFH_HDR_BYTES    8'h07

// Frame lengths including the two CRC bytes, and the data offset of a read reply
`define MBFH_LEN_FIXED    8'h08
`define MBFH_LEN_MIN      8'h04
`define MBFH_LEN_DIAG_MIN 8'h06
`define MBFH_LEN_EXC      8'h05
`define MBFH_LEN_RD_BASE  8'h05
`define MBFH_LEN_WRN_BASE 8'h09
`define MBFH_RD_DATA_OFS  8'h03

`define MBFH_MAX_WRN      16
`define MBFH_MAX_RD       16

// Reply kinds
`define MBFH_K_ECHO       2'h0
`define MBFH_K_READ       2'h1
`define MBFH_K_WRN        2'h2
`define MBFH_K_EXC        2'h3

`endif

// ===== mbfh_master.sv
// Bus master model: sends queries, collects reply bytes
module mbfh_master (
	input  wire logic       i_core_clk,
	output logic      [7:0] o_rx_data,
	output logic            o_rx_valid,
	output logic            o_frame_end,
	input  wire logic [7:0] i_tx_data,
	input  wire logic       i_tx_valid,
	output logic            o_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got[$];
	logic       slow = 1'h0;
	initial
	begin
		o_rx_data = 8'h00;
		o_rx_valid = 1'h0;
		o_frame_end = 1'h0;
		o_ready = 1'h0;
	end
	function automatic logic [15:0] crc(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (b[i])
		begin
			c = c ^ {8'h00, b[i]};
			repeat (8)
				c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return c;
	endfunction
	////////////////////////////////////////
	// Line is not held after a byte: inverse value shown
	task automatic send(input logic [7:0] q[$], input logic bad);
		logic [15:0] c;
		c = crc(q) ^ {15'h0, bad};
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		foreach (q[i])
		begin
			@(negedge i_core_clk);
			o_rx_data = q[i];
			o_rx_valid = 1'h1;
			@(negedge i_core_clk);
			o_rx_data = ~q[i];
			o_rx_valid = 1'h0;
		end
		@(negedge i_core_clk);
		o_frame_end = 1'h1;
		@(negedge i_core_clk);
		o_frame_end = 1'h0;
	endtask
	always @(negedge i_core_clk)
		o_ready <= slow ? ~o_ready : 1'h1;
	always @(posedge i_core_clk)
		if (o_ready && i_tx_valid)
			got.push_back(i_tx_data);
endmodule // mbfh_master

// ===== mbfh_mem.v
// Simple synchronous memory with registered read data
module mbfh_mem #(
	parameter WIDTH = 16,
	parameter DEPTH = 256,
	parameter AW    = 8
) (
	input  wire             i_core_clk,
	input  wire             i_rst,
	input  wire             i_wr_en,
	input  wire [AW-1:0]    i_wr_addr,
	input  wire [WIDTH-1:0] i_wr_data,
	input  wire [AW-1:0]    i_rd_addr,
	output reg  [WIDTH-1:0] o_rd_data
);

	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];

	always @(posedge i_core_clk)
	begin
		if (i_wr_en)
			mem_reg[i_wr_addr] <= i_wr_data;
	end

	always @(posedge i_core_clk)
	begin
		if (i_rst)
			o_rd_data <= {WIDTH{1'b0}};
		else
			o_rd_data <= mem_reg[i_rd_addr];
	end

endmodule // mbfh_mem

// ===== mbfh_top.v
// Function code handler: parses query frames, commits writes, builds replies
//
// Summary of operation
// - Read reply byte count is twice quantity.
// - Register values travel upper byte first.
// - Frame ends with CRC, low byte first.
// - Single write stores value, echoes the query.
// - Diagnosis returns the received frame unchanged.
// - Diagnosis accepts only sub-function zero.
// - Multiple write fills consecutive registers from start.
// - Multiple write covers at most sixteen registers.
// - Multiple write commits in ascending address order.
// - Bad addresses give exception; good ones stay.
// - Multiple write reply copies header, fresh CRC.
// - Even address upper half, odd lower half.
`include "mbfh_defines.vh"

module mbfh_top #(
	parameter REG_DEPTH = 256,
	parameter REG_AW    = 8,
	parameter FB_DEPTH  = 64,
	parameter FB_AW     = 6
) (
	input  wire              i_core_clk,
	input  wire              i_rst,
	input  wire [7:0]        i_slave_addr,
	input  wire [7:0]        i_rx_data,
	input  wire              i_rx_valid,
	input  wire              i_rx_frame_end,
	output reg  [7:0]        o_tx_data,
	output reg               o_tx_valid,
	input  wire              i_tx_ready,
	output reg               o_commit_valid,
	output reg  [15:0]       o_commit_addr,
	output reg  [15:0]       o_commit_data,
	output reg               o_busy
);

	localparam [2:0] S_IDLE  = 3'h0;
	localparam [2:0] S_WR    = 3'h1;
	localparam [2:0] S_FETCH = 3'h2;
	localparam [2:0] S_LOAD  = 3'h3;
	localparam [2:0] S_SEND  = 3'h4;
	localparam [16:0] REG_LIM = REG_DEPTH;
	localparam [7:0]  FB_LIM  = FB_DEPTH;

	////////////////////////////////////////////////////////////////////////////////
	// CRC-16, one byte, least significant bit first
	function [15:0] crc_step;
		input [15:0] c;
		input [7:0]  d;
		integer      i;
		reg   [15:0] x;
		begin
			x = c ^ {8'h00, d};
			for (i = 0; i < 8; i = i + 1)
				x = x[0] ? ((x >> 1) ^ `MBFH_CRC_POLY) : (x >> 1);
			crc_step = x;
		end
	endfunction

	reg [2:0]   state_reg;
	reg [7:0]   rx_cnt_reg;
	reg         rx_ovf_reg;
	reg [15:0]  rx_crc_reg;
	reg [7:0]   hdr_reg [0:6];
	reg [1:0]   kind_reg;
	reg [7:0]   tx_idx_reg;
	reg [7:0]   tx_len_reg;
	reg [15:0]  tx_crc_reg;
	reg [4:0]   wr_cnt_reg;
	reg [1:0]   wr_ph_reg;
	reg [7:0]   wr_hi_reg;
	reg         wr_bad_reg;
	reg [7:0]   data_base_reg;
	reg [7:0]   tx_byte;

	wire [7:0]  fn        = hdr_reg[1];
	wire [15:0] start     = {hdr_reg[2], hdr_reg[3]};
	wire [15:0] qty       = {hdr_reg[4], hdr_reg[5]};
	wire [7:0]  byte_cnt  = hdr_reg[6];
	wire [7:0]  qty2      = {qty[6:0], 1'b0};
	wire [7:0]  tx_body   = tx_len_reg - 8'h02;
	wire [7:0]  rd_ofs    = tx_idx_reg - `MBFH_RD_DATA_OFS;
	wire [15:0] rd_reg    = start + {9'h000, rd_ofs[7:1]};
	wire [15:0] wr_reg    = start + {11'h000, wr_cnt_reg};
	wire        wr_in     = ({1'b0, wr_reg} < REG_LIM);
	wire [16:0] rd_end    = {1'b0, start} + {1'b0, qty};
	wire [7:0]  wr_fb_ofs = data_base_reg + {2'b00, wr_cnt_reg, 1'b0} + {7'h00, wr_ph_reg[0]};
	wire [7:0]  fb_ofs    = (state_reg == S_WR) ? wr_fb_ofs : tx_idx_reg;
	// A single write has no quantity field: its one register is always the last
	wire        wr_last   = (kind_reg == `MBFH_K_ECHO) ||
	                        ({11'h000, wr_cnt_reg} == qty - 16'h0001);
	wire        reg_we    = (state_reg == S_WR) && (wr_ph_reg == 2'h2) && wr_in;
	wire [7:0]  fb_rd_data;
	wire [15:0] reg_rd_data;

	////////////////////////////////////////////////////////////////////////////////
	// Frame byte buffer and register store
	mbfh_mem #(.WIDTH(8), .DEPTH(FB_DEPTH), .AW(FB_AW)) u_frame_buf (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_wr_en    (i_rx_valid && (state_reg == S_IDLE) && (rx_cnt_reg < FB_LIM)),
		.i_wr_addr  (rx_cnt_reg[FB_AW-1:0]),
		.i_wr_data  (i_rx_data),
		.i_rd_addr  (fb_ofs[FB_AW-1:0]),
		.o_rd_data  (fb_rd_data)
	);

	mbfh_mem #(.WIDTH(16), .DEPTH(REG_DEPTH), .AW(REG_AW)) u_reg_store (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_wr_en    (reg_we),
		.i_wr_addr  (wr_reg[REG_AW-1:0]),
		.i_wr_data  ({wr_hi_reg, fb_rd_data}),
		.i_rd_addr  (rd_reg[REG_AW-1:0]),
		.o_rd_data  (reg_rd_data)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Reply byte selection
	always @*
	begin
		tx_byte = 8'h00;
		if (tx_idx_reg == tx_body)
			tx_byte = tx_crc_reg[7:0];
		else if (tx_idx_reg > tx_body)
			tx_byte = tx_crc_reg[15:8];
		else
		begin
			case (kind_reg)
				`MBFH_K_ECHO: tx_byte = fb_rd_data;
				`MBFH_K_READ:
				begin
					if (tx_idx_reg < `MBFH_RD_DATA_OFS)
						tx_byte = (tx_idx_reg == 8'h02) ? qty2 : hdr_reg[tx_idx_reg[0]];
					else
						tx_byte = rd_ofs[0] ? reg_rd_data[7:0] : reg_rd_data[15:8];
				end
				`MBFH_K_WRN: tx_byte = hdr_reg[tx_idx_reg[2:0]];
				`MBFH_K_EXC:
				begin
					if (tx_idx_reg == 8'h00)
						tx_byte = hdr_reg[0];
					else if (tx_idx_reg == 8'h01)
						tx_byte = fn | `MBFH_EXC_FLAG;
					else
						tx_byte = `MBFH_EXC_ADDR;
				end
				default: tx_byte = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receive side: count, capture header, run CRC
	always @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			rx_cnt_reg <= 8'h00;
			rx_ovf_reg <= 1'b0;
			rx_crc_reg <= `MBFH_CRC_INIT;
		end
		else if (i_rx_frame_end)
		begin
			rx_cnt_reg <= 8'h00;
			rx_ovf_reg <= 1'b0;
			rx_crc_reg <= `MBFH_CRC_INIT;
		end
		else if (i_rx_valid && (state_reg == S_IDLE))
		begin
			if (rx_cnt_reg < FB_LIM)
				rx_cnt_reg <= rx_cnt_reg + 8'h01;
			else
				rx_ovf_reg <= 1'b1;
			rx_crc_reg <= crc_step(rx_crc_reg, i_rx_data);
		end
	end

	always @(posedge i_core_clk)
	begin
		if (i_rx_valid && (state_reg == S_IDLE) && (rx_cnt_reg < `MBFH_HDR_BYTES))
			hdr_reg[rx_cnt_reg[2:0]] <= i_rx_data;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequencer
	always @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			state_reg      <= S_IDLE;
			kind_reg       <= `MBFH_K_ECHO;
			tx_idx_reg     <= 8'h00;
			tx_len_reg     <= 8'h00;
			tx_crc_reg     <= `MBFH_CRC_INIT;
			wr_cnt_reg     <= 5'h00;
			wr_ph_reg      <= 2'h0;
			wr_hi_reg      <= 8'h00;
			wr_bad_reg     <= 1'b0;
			data_base_reg  <= 8'h00;
			o_tx_data      <= 8'h00;
			o_tx_valid     <= 1'b0;
			o_commit_valid <= 1'b0;
			o_commit_addr  <= 16'h0000;
			o_commit_data  <= 16'h0000;
			o_busy         <= 1'b0;
		end
		else
		begin
			o_commit_valid <= 1'b0;
			case (state_reg)
				S_IDLE:
				begin
					o_busy     <= 1'b0;
					tx_idx_reg <= 8'h00;
					tx_crc_reg <= `MBFH_CRC_INIT;
					wr_cnt_reg <= 5'h00;
					wr_ph_reg  <= 2'h0;
					wr_bad_reg <= 1'b0;
					// Bad CRC, foreign address or overflow: no reply at all
					if (i_rx_frame_end && !rx_ovf_reg && (rx_cnt_reg >= `MBFH_LEN_MIN) &&
						(rx_crc_reg == 16'h0000) && (hdr_reg[0] == i_slave_addr))
					begin
						case (fn)
							`MBFH_FN_READ:
							begin
								if ((rx_cnt_reg == `MBFH_LEN_FIXED) && (qty != 16'h0000) &&
									(qty <= `MBFH_MAX_RD))
								begin
									o_busy    <= 1'b1;
									state_reg <= S_FETCH;
									if (rd_end > REG_LIM)
									begin
										kind_reg   <= `MBFH_K_EXC;
										tx_len_reg <= `MBFH_LEN_EXC;
									end
									else
									begin
										kind_reg   <= `MBFH_K_READ;
										tx_len_reg <= `MBFH_LEN_RD_BASE + qty2;
									end
								end
							end
							`MBFH_FN_WRITE1:
							begin
								if (rx_cnt_reg == `MBFH_LEN_FIXED)
								begin
									o_busy        <= 1'b1;
									data_base_reg <= `MBFH_OFS_DATA1;
									kind_reg      <= `MBFH_K_ECHO;
									tx_len_reg    <= `MBFH_LEN_FIXED;
									state_reg     <= S_WR;
								end
							end
							`MBFH_FN_DIAG:
							begin
								if ((rx_cnt_reg >= `MBFH_LEN_DIAG_MIN) && (start == `MBFH_SUB_ECHO))
								begin
									o_busy     <= 1'b1;
									kind_reg   <= `MBFH_K_ECHO;
									tx_len_reg <= rx_cnt_reg;
									state_reg  <= S_FETCH;
								end
							end
							`MBFH_FN_WRITEN:
							begin
								if ((qty != 16'h0000) && (qty <= `MBFH_MAX_WRN) &&
									(byte_cnt == qty2) &&
									(rx_cnt_reg == `MBFH_LEN_WRN_BASE + byte_cnt))
								begin
									o_busy        <= 1'b1;
									data_base_reg <= `MBFH_OFS_DATAN;
									kind_reg      <= `MBFH_K_WRN;
									tx_len_reg    <= `MBFH_LEN_FIXED;
									state_reg     <= S_WR;
								end
							end
							default: state_reg <= S_IDLE;
						endcase
					end
				end
				S_WR:
				begin
					// Upper byte read first, lower byte arrives one cycle later
					if (wr_ph_reg == 2'h1)
					begin
						wr_hi_reg <= fb_rd_data;
						wr_ph_reg <= 2'h2;
					end
					else if (wr_ph_reg == 2'h2)
					begin
						wr_ph_reg <= 2'h0;
						if (wr_in)
						begin
							o_commit_valid <= 1'b1;
							o_commit_addr  <= wr_reg;
							o_commit_data  <= {wr_hi_reg, fb_rd_data};
						end
						// Earlier good values stay written
						if (wr_last)
						begin
							state_reg <= S_FETCH;
							if (wr_bad_reg || !wr_in)
							begin
								kind_reg   <= `MBFH_K_EXC;
								tx_len_reg <= `MBFH_LEN_EXC;
							end
						end
						else
						begin
							wr_bad_reg <= wr_bad_reg | !wr_in;
							wr_cnt_reg <= wr_cnt_reg + 5'h01;
						end
					end
					else
						wr_ph_reg <= 2'h1;
				end
				S_FETCH: state_reg <= S_LOAD;
				S_LOAD:
				begin
					o_tx_data  <= tx_byte;
					o_tx_valid <= 1'b1;
					if (tx_idx_reg < tx_body)
						tx_crc_reg <= crc_step(tx_crc_reg, tx_byte);
					state_reg  <= S_SEND;
				end
				S_SEND:
				begin
					if (i_tx_ready)
					begin
						o_tx_valid <= 1'b0;
						tx_idx_reg <= tx_idx_reg + 8'h01;
						state_reg  <= (tx_idx_reg == tx_len_reg - 8'h01) ? S_IDLE : S_FETCH;
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

endmodule // mbfh_top

// ===== test_modbus_rtu_slave_function_handler.sv
// Self-checking bench of the function handler
module test_modbus_rtu_slave_function_handler;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] sa; logic [95:0] q; int ql; logic [95:0] r; int rl;} mbfh_row_t;
	logic        clk;
	logic        i_rst;
	logic [7:0]  i_slave_addr;
	logic [7:0]  rxd, txd;
	logic        rxv, fe, txv, rdy, cv, busy;
	logic [15:0] ca, cd;
	logic [31:0] cq[$];
	int          error_cnt = 0;
	int          tests_run = 0;
	mbfh_row_t   rows[8] = '{
		'{8'h03, 96'h0308_0000_1234, 6, 96'h0308_0000_1234, 6},
		'{8'h02, 96'h0206_004b_0050, 6, 96'h0206_004b_0050, 6},
		'{8'h04, 96'h0410_0004_0002_0400_07a1_20, 11, 96'h0410_0004_0002, 6},
		'{8'h04, 96'h0403_0004_0002, 6, 96'h0403_0400_07a1_20, 7},
		'{8'h03, 96'h0308_0001_1234, 6, 96'h0, 0},
		'{8'h05, 96'h0406_0010_0001, 6, 96'h0, 0},
		'{8'h04, 96'h0410_00ff_0002_04ab_cd12_34, 11, 96'h0490_02, 3},
		'{8'h04, 96'h0403_00ff_0001, 6, 96'h0403_02ab_cd, 5}};
	mbfh_top mbfh_top_inst (.i_core_clk(clk), .i_rst(i_rst), .i_slave_addr(i_slave_addr),
		.i_rx_data(rxd), .i_rx_valid(rxv), .i_rx_frame_end(fe), .o_tx_data(txd),
		.o_tx_valid(txv), .i_tx_ready(rdy), .o_commit_valid(cv), .o_commit_addr(ca),
		.o_commit_data(cd), .o_busy(busy));
	mbfh_master mbfh_master_inst (.i_core_clk(clk), .o_rx_data(rxd), .o_rx_valid(rxv),
		.o_frame_end(fe), .i_tx_data(txd), .i_tx_valid(txv), .o_ready(rdy));
	always @(posedge clk)
		if (cv === 1'h1)
			cq.push_back({ca, cd});
	////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic run(input int k, input logic bad);
		logic [7:0]  q[$];
		logic [7:0]  e[$];
		logic [15:0] c;
		int          n;
		mbfh_master_inst.got.delete();
		mbfh_master_inst.slow = k[0];
		for (int i = rows[k].ql - 1; i >= 0; i--)
			q.push_back(rows[k].q[8*i+:8]);
		for (int i = rows[k].rl - 1; i >= 0; i--)
			e.push_back(rows[k].r[8*i+:8]);
		if (!bad && e.size() > 0)
		begin
			c = mbfh_master_inst.crc(e);
			e.push_back(c[7:0]);
			e.push_back(c[15:8]);
		end
		if (bad)
			e.delete();
		@(negedge clk);
		i_slave_addr = rows[k].sa;
		mbfh_master_inst.send(q, bad);
		n = 0;
		while (n < 900 && !(n > 20 && busy === 1'h0 && mbfh_master_inst.got.size() == e.size()))
		begin
			@(posedge clk);
			n++;
		end
		if (n == 900)
		begin
			error_cnt++;
			report_and_stop();
		end
		check("reply length", mbfh_master_inst.got.size(), e.size());
		foreach (e[i])
			check("reply byte", mbfh_master_inst.got[i], e[i]);
		$display("test %0d done", k);
	endtask
	////////////////////////////////////////
	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		i_rst = 1'h1;
		i_slave_addr = 8'h00;
		repeat (20) @(negedge clk);
		check("reset outputs", {txv, cv, busy}, 3'h0);
		i_rst = 1'h0;
		$display("test reset done");
		foreach (rows[k])
			run(k, 1'h0);
		run(0, 1'h1);
		check("commit count", cq.size(), 4);
		foreach (cq[i])
			check("commit", cq[i], i == 0 ? 32'h004b_0050 : i == 1 ? 32'h0004_0007 :
				i == 2 ? 32'h0005_a120 : 32'h00ff_abcd);
		report_and_stop();
	end
endmodule // test_modbus_rtu_slave_function_handler
